// ==== far_side_model.sv ====
// Model of the supply monitor, watchdog and debugger.
`timescale 1ns/10ps
module far_side_model (
  input  wire logic                      sysReset,
  input  wire reset_seq_pkg::reset_req_s cmd,
  output reset_seq_pkg::reset_req_s      req
);
  import reset_seq_pkg::*;
  // The debugger bit survives the reset it orders.
  always_comb begin
    req = cmd;
    if (sysReset) begin
      req.wdtTimeout = 1'b0;
    end
  end
endmodule : far_side_model

// ==== reset_seq_chk.sv ====
// Checker on the ports of the reset source sequencer.
`timescale 1ns/10ps
module reset_seq_chk
  import reset_seq_pkg::*;
#(parameter int unsigned PorIntCycles = 8) (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      resetPin_n,
  input wire reset_seq_pkg::reset_req_s req,
  input wire logic                      porFlagClear,
  input wire logic                      sysReset,
  input wire logic                      fetchVector,
  input wire logic                      porFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence pinBlip;
    resetPin_n ##1 !resetPin_n [*2] ##1 resetPin_n;
  endsequence
  sequence pinHeld;
    (!req.stopMode && resetPin_n) ##1 !resetPin_n [*3];
  endsequence
  AST_PIN_SHORT: assert property ((!sysReset ##0 pinBlip) |=>
    !sysReset [*6]) else $error("short pin pulse reset");
  AST_PIN_LONG: assert property (pinHeld |-> ##4 sysReset)
    else $error("long pin pulse ignored");
  AST_DEBUG: assert property (req.debugReset |-> ##[1:4] sysReset)
    else $error("debugger reset missed");
  AST_WDT: assert property (req.wdtTimeout && req.wdtResetMode &&
    !req.stopMode |-> ##[1:4] sysReset) else $error("watchdog missed");
  AST_STOP: assert property (req.stopMode && req.stopPinReset
    |-> ##[1:5] sysReset) else $error("stop pin reset missed");
  AST_HOLD: assert property ($fell(sysReset) |->
    $past(sysReset, PorIntCycles)) else $error("delay cut short");
  AST_FETCH: assert property ($fell(sysReset) |->
    fetchVector ##1 !fetchVector) else $error("no vector fetch");
  AST_FLAG: assert property (porFlag && !porFlagClear |=> porFlag)
    else $error("flag lost");
endmodule : reset_seq_chk

bind reset_source_sequencer reset_seq_chk #(.PorIntCycles(PorIntCycles))
  chk_u (.clk(clk), .rst_n(rst_n), .resetPin_n(resetPin_n), .req(req),
  .porFlagClear(porFlagClear), .sysReset(sysReset),
  .fetchVector(fetchVector), .porFlag(porFlag));

// ==== reset_seq_pkg.sv ====
// Package with constants and types for the reset source sequencer.
package reset_seq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned PIN_MIN_CYCLES  = 3;
  localparam int unsigned POR_INT_CYCLES  = 5000;
  localparam int unsigned POR_XTAL_CYCLES = 10000;
  localparam int unsigned CNT_W           = 16;
  localparam logic [1:0]  SYNC_INIT       = 2'h3;
  localparam logic [2:0]  PIN_SYNC_INIT   = 3'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_POR     = 2'b00,
    ST_DELAY   = 2'b01,
    ST_RUN     = 2'b10,
    ST_WARM    = 2'b11
  } seq_state_e;

  typedef struct packed {
    logic supplyOk;
    logic wdtTimeout;
    logic wdtResetMode;
    logic debugReset;
    logic stopMode;
    logic stopPinReset;
    logic xtalEnable;
  } reset_req_s;

  typedef struct packed {
    logic sysReset;
    logic fetchVector;
    logic porFlag;
  } reset_out_s;

endpackage : reset_seq_pkg

// ==== reset_source_sequencer.sv ====
// Reset source gathering and power-on sequencing logic.
`timescale 1ns/10ps

// Behaviour
// - Ignore reset pin pulses under three clocks.
// - Debugger control bit zero forces system reset.
// - Watchdog timeout resets when set for reset, except in stop.
// - In stop, analog filtered pin resets.
// - Hold reset until power-on counter expires.
// - Crystal option lengthens power-on count.
// - On release, CPU fetches reset vector.
// - Power-on reset sets power-on status flag.
module reset_source_sequencer #(
  parameter int unsigned PorIntCycles  = reset_seq_pkg::POR_INT_CYCLES,
  parameter int unsigned PorXtalCycles = reset_seq_pkg::POR_XTAL_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      resetPin_n,
  input  wire reset_seq_pkg::reset_req_s req,
  input  wire logic                      porFlagClear,
  output logic                           sysReset,
  output logic                           fetchVector,
  output logic                           porFlag
);
  import reset_seq_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // A synchronised level counts only once stages two and three agree,
  // which costs one cycle but keeps a metastable first stage out.
  function automatic logic agreedHigh(input logic [2:0] stages);
    return stages[1] && stages[2];
  endfunction : agreedHigh

  function automatic logic agreedLow(input logic [2:0] stages);
    return !stages[1] && !stages[2];
  endfunction : agreedLow

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  // Pin passes three stages; the first stage feeds only the second.
  // Supply and stop-pin requests are asynchronous as well, so they get
  // the same three stages and the same agreement test.
  logic [2:0] pinSync;
  logic [2:0] next_pinSync;
  logic [2:0] supSync;
  logic [2:0] next_supSync;
  logic [2:0] stopSync;
  logic [2:0] next_stopSync;
  logic       pinLow;
  logic       supHigh;
  logic       supLow;
  logic       stopHigh;

  always_comb begin
    next_pinSync  = {pinSync[1:0], resetPin_n};
    next_supSync  = {supSync[1:0], req.supplyOk};
    next_stopSync = {stopSync[1:0], req.stopPinReset};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync  <= PIN_SYNC_INIT;
      supSync  <= '0;
      stopSync <= '0;
    end else begin
      pinSync  <= next_pinSync;
      supSync  <= next_supSync;
      stopSync <= next_stopSync;
    end
  end

  // A change counts once stages two and three agree.
  assign pinLow   = agreedLow(pinSync);
  assign supHigh  = agreedHigh(supSync);
  assign supLow   = agreedLow(supSync);
  assign stopHigh = agreedHigh(stopSync);

  // ****************************************************************
  // Pin pulse qualifier
  // ****************************************************************
  // Stages two and three agree for one cycle fewer than the pin is low,
  // so the minimum width shows up as one agreed cycle less.
  localparam logic [1:0] PinAgreeCnt = 2'(PIN_MIN_CYCLES - 1);

  logic [1:0] pinCnt;
  logic [1:0] next_pinCnt;
  logic       pinReset;

  always_comb begin
    next_pinCnt = 2'h0;
    if (pinLow && !req.stopMode) begin
      if (pinCnt < PinAgreeCnt) begin
        next_pinCnt = pinCnt + 2'h1;
      end else begin
        next_pinCnt = pinCnt;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinCnt <= 2'h0;
    end else begin
      pinCnt <= next_pinCnt;
    end
  end

  // The count saturates, so a pin held low keeps the request standing.
  assign pinReset = (pinCnt == PinAgreeCnt);

  // ****************************************************************
  // Warm reset sources
  // ****************************************************************
  logic warmReq;
  // Stop-mode pin request is already filtered by the analog delay, so
  // only synchronisation is applied here.
  assign warmReq = pinReset
                 || (stopHigh && req.stopMode)
                 || req.debugReset
                 || (req.wdtTimeout && req.wdtResetMode && !req.stopMode);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  seq_state_e       state;
  seq_state_e       next_state;
  logic [CNT_W-1:0] porCnt;
  logic [CNT_W-1:0] next_porCnt;
  logic [CNT_W-1:0] porLimit;
  logic             next_sysReset;
  logic             next_fetchVector;
  logic             next_porFlag;
  logic             porSeen;
  logic             next_porSeen;

  // Limit is sampled every cycle; option bits are static in practice.
  assign porLimit = req.xtalEnable ? CNT_W'(PorXtalCycles - 1)
                                   : CNT_W'(PorIntCycles - 1);

  always_comb begin
    next_state       = state;
    next_porCnt      = porCnt;
    next_sysReset    = 1'b1;
    next_fetchVector = 1'b0;
    next_porFlag     = porFlag;
    next_porSeen     = porSeen;
    if (porFlagClear) begin
      next_porFlag = 1'b0;
    end
    case (state)
      ST_POR: begin
        next_porCnt  = '0;
        next_porSeen = 1'b1;
        if (supHigh) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (supLow) begin
          next_state = ST_POR;
        end else if (warmReq) begin
          // A fresh warm request restarts the delay instead of being lost.
          next_state = ST_WARM;
        end else if (porCnt >= porLimit) begin
          next_state       = ST_RUN;
          next_sysReset    = 1'b0;
          next_fetchVector = 1'b1;
          if (porSeen) begin
            next_porFlag = 1'b1;
          end
          next_porSeen = 1'b0;
        end else begin
          next_porCnt = porCnt + CNT_W'(1);
        end
      end
      ST_RUN: begin
        next_sysReset = 1'b0;
        // Supply loss outranks every warm source.
        if (supLow) begin
          next_state    = ST_POR;
          next_sysReset = 1'b1;
        end else if (warmReq) begin
          next_state    = ST_WARM;
          next_sysReset = 1'b1;
        end
      end
      ST_WARM: begin
        // Warm resets rerun the delay but keep the power-on flag alone.
        next_porCnt = '0;
        if (supLow) begin
          next_state = ST_POR;
        end else if (!warmReq) begin
          next_state = ST_DELAY;
        end
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_POR;
      porCnt      <= '0;
      sysReset    <= 1'b1;
      fetchVector <= 1'b0;
      porFlag     <= 1'b0;
      porSeen     <= 1'b0;
    end else begin
      state       <= next_state;
      porCnt      <= next_porCnt;
      sysReset    <= next_sysReset;
      fetchVector <= next_fetchVector;
      porFlag     <= next_porFlag;
      porSeen     <= next_porSeen;
    end
  end

endmodule : reset_source_sequencer

// ==== testbench.sv ====
// Self-checking bench for the reset source sequencer.
`timescale 1ns/10ps
module testbench;
  import reset_seq_pkg::*;
  logic       clk, rst_n, resetPin_n, porFlagClear;
  logic       sysReset, fetchVector, porFlag;
  reset_req_s cmd, req;
  int         nErrors, checked;
  far_side_model far_u (.sysReset(sysReset), .cmd(cmd), .req(req));
  reset_source_sequencer #(.PorIntCycles(8), .PorXtalCycles(16)) dut_u (
    .clk(clk), .rst_n(rst_n), .resetPin_n(resetPin_n), .req(req),
    .porFlagClear(porFlagClear), .sysReset(sysReset),
    .fetchVector(fetchVector), .porFlag(porFlag));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      nErrors++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic untilFetch(output logic [7:0] n);
    n = 8'h00;
    while (fetchVector !== 1'b1 && n < 8'h40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("fetch", 8'h01, {7'h0, fetchVector});
    chk("release", 8'h00, {7'h0, sysReset});
    cyc(2);
    chk("pulse", 8'h00, {7'h0, fetchVector});
  endtask : untilFetch
  task automatic t_powerOn(logic xtal, logic [7:0] lim);
    logic [7:0] n;
    cmd.supplyOk = 1'b0;
    cmd.xtalEnable = xtal;
    porFlagClear = 1'b1;
    cyc(1);
    porFlagClear = 1'b0;
    cyc(3);
    chk("reset", 8'h01, {7'h0, sysReset});
    chk("cleared", 8'h00, {7'h0, porFlag});
    cmd.supplyOk = 1'b1;
    untilFetch(n);
    // Three sync stages plus the ST_POR to ST_DELAY step precede the delay.
    chk("edges", lim + 8'h04, n);
    chk("porFlag", 8'h01, {7'h0, porFlag});
  endtask : t_powerOn
  // Warm resets must leave the cleared power-on flag alone.
  task automatic warm(logic e);
    logic [7:0] n;
    // Requests stand four cycles so the three-stage stop path sees them.
    cyc(4);
    cmd.debugReset = 1'b0;
    cmd.wdtTimeout = 1'b0;
    cmd.stopPinReset = 1'b0;
    cyc(4);
    chk("warm", {7'h0, e}, {7'h0, sysReset});
    if (e) untilFetch(n);
    chk("flag", 8'h00, {7'h0, porFlag});
  endtask : warm
  task automatic t_pin;
    porFlagClear = 1'b1;
    cyc(1);
    porFlagClear = 1'b0;
    resetPin_n = 1'b0;
    cyc(2);
    resetPin_n = 1'b1;
    warm(1'b0);
    resetPin_n = 1'b0;
    cyc(3);
    resetPin_n = 1'b1;
    warm(1'b1);
  endtask : t_pin
  task automatic t_src;
    cmd.debugReset = 1'b1;
    warm(1'b1);
    cmd.wdtTimeout = 1'b1;
    warm(1'b0);
    cmd.wdtResetMode = 1'b1;
    cmd.wdtTimeout = 1'b1;
    warm(1'b1);
    cmd.stopMode = 1'b1;
    cmd.wdtTimeout = 1'b1;
    warm(1'b0);
    cmd.stopPinReset = 1'b1;
    warm(1'b1);
  endtask : t_src
  task automatic tally_and_finish;
    if (nErrors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    rst_n = 1'b0;
    resetPin_n = 1'b1;
    porFlagClear = 1'b0;
    cmd = '0;
    cyc(10);
    rst_n = 1'b1;
    t_powerOn(1'b0, 8'h08);
    t_powerOn(1'b1, 8'h10);
    t_pin;
    t_src;
    tally_and_finish;
  end
  initial begin
    cyc(2000);
    nErrors++;
    tally_and_finish;
  end
endmodule : testbench
